// ---- core/scs_sys_ctrl.sv ----
// How it works
// - on bus fault, rerun if halt also low outside slow peripheral cycles, else end with fault exception.
// - reset and halt lines low together from outside start system init.
// - reset instruction drives reset line low; internal state stays untouched.
// - external halt stops after current cycle; controls idle, buses float.
// - when the core stops, drive the halt line low.
// - width strap low gives 8-bit mode, high or open gives 16-bit.
// - enable clock period ten clocks: six low then four high.
// - enable clock from a free-running ring, any start phase.
// - slow peripheral select makes the transfer follow the enable clock.
// - slow peripheral select during interrupt acknowledge means autovector.
// - valid address strobe to slow peripherals only after their select.
// - space code: 001 ud, 010 up, 101 sd, 110 sp, 111 cpu.
// - space code stays valid while the address strobe is asserted.
// - halt floats address and data; relinquish floats controls too.
// - transfer acknowledge ends a cycle; reads latch data first.
// - interrupt acknowledge drives all space code and address 19..16 high.
`timescale 1ns/1ns
`include "scs_defs.svh"

module scs_sys_ctrl (
  input  wire logic              core_clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              req_valid_in,
  input  wire scs_pkg::scs_req_s req_in,
  output logic                   req_ready_out,
  output logic                   rsp_valid_out,
  output scs_pkg::scs_rsp_s      rsp_out,
  input  wire logic              reset_instr_in,
  input  wire logic              core_stopped_in,
  input  wire logic              relinquish_req_in,
  output logic                   sys_init_out,
  output logic                   bus_8bit_out,
  input  wire logic              bus_fault_n_in,
  input  wire logic              transfer_ack_n_in,
  input  wire logic              slow_peripheral_select_n_in,
  input  wire logic              width_sel_in,
  input  wire logic              rst_line_n_in,
  output logic                   rst_line_n_out,
  output logic                   rst_line_oe_out,
  input  wire logic              halt_line_n_in,
  output logic                   halt_line_n_out,
  output logic                   halt_line_oe_out,
  output scs_pkg::scs_pins_s     pins_out,
  output logic                   addr_oe_out,
  output logic                   ctrl_oe_out,
  input  wire logic [15:0]       data_in,
  output logic [15:0]            data_out,
  output logic                   data_oe_out,
  output logic                   bus_handover_grant_n_out,
  output logic                   periph_en_clk_out
);

  scs_pkg::scs_state_e        st_r;
  scs_pkg::scs_state_e        st_nxt;
  scs_pkg::scs_req_s          cur_r;
  scs_pkg::scs_rsp_s          rsp_r;
  scs_pkg::scs_pins_s         pins_r;
  scs_pkg::scs_pins_s         pins_nxt;
  logic [`SCS_E_PH_W-1:0]     e_ph;
  logic [`SCS_RST_CNT_W-1:0]  rst_cnt_r;
  logic [15:0]                wdata_r;
  logic                       rsp_valid_r;
  logic                       rst_drv_r;
  logic                       halt_drv_r;
  logic                       in_rst_r;
  logic                       mode_r;
  logic                       sys_init_r;
  logic                       grant_r;
  logic                       wr_on_r;

  ////////////////////////////////////////////////////////////////////////////
  // enable clock ring
  scs_eclk_gen u_eclk (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .e_clk_out   (periph_en_clk_out),
    .e_phase_out (e_ph)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin decode; our own drive is masked so we never see ourselves
  wire fault_w    = !bus_fault_n_in;
  wire ack_w      = !transfer_ack_n_in;
  wire slow_sel_w = !slow_peripheral_select_n_in;
  wire ext_halt_w = !halt_line_n_in && !halt_drv_r;
  wire ext_rst_w  = !rst_line_n_in && !rst_drv_r;
  wire idle_w     = (st_r == scs_pkg::ST_IDLE);
  wire start_w    = req_valid_in && req_ready_out;
  wire done_w     = (st_nxt == scs_pkg::ST_END) &&
                    ((st_r == scs_pkg::ST_WAIT) || (st_r == scs_pkg::ST_PER));
  wire fault_end_w = done_w && fault_w;
  wire per_exit_w = !pins_r.slow_peripheral_addr_valid_n &&
                    (e_ph == `SCS_E_PH_LAST);
  wire halted_w   = ext_halt_w &&
                    (idle_w || (st_r == scs_pkg::ST_RERUN));

  // new cycles held off by halt, relinquish or our own stop
  assign req_ready_out = idle_w && !ext_halt_w && !grant_r && !halt_drv_r;

  ////////////////////////////////////////////////////////////////////////////
  // cycle sequencer
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      scs_pkg::ST_IDLE: begin
        if (start_w) st_nxt = scs_pkg::ST_ADDR;
      end
      scs_pkg::ST_ADDR:  st_nxt = scs_pkg::ST_STRB;
      scs_pkg::ST_STRB:  st_nxt = scs_pkg::ST_WAIT;
      scs_pkg::ST_WAIT: begin
        // fault outranks acknowledge: a late fault must not be swallowed
        if (fault_w && ext_halt_w) st_nxt = scs_pkg::ST_RERUN;
        else if (fault_w) st_nxt = scs_pkg::ST_END;
        else if (ack_w) st_nxt = scs_pkg::ST_END;
        else if (slow_sel_w) st_nxt = scs_pkg::ST_PER;
      end
      scs_pkg::ST_PER: begin
        if (fault_w || per_exit_w) st_nxt = scs_pkg::ST_END;
      end
      scs_pkg::ST_END:   st_nxt = scs_pkg::ST_IDLE;
      scs_pkg::ST_RERUN: begin
        if (!ext_halt_w) st_nxt = scs_pkg::ST_ADDR;
      end
      default:           st_nxt = scs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) st_r <= scs_pkg::ST_IDLE;
    else st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next pin values; strobes only in strobe, wait and peripheral states
  wire strb_nxt_w = (st_nxt == scs_pkg::ST_STRB) || (st_nxt == scs_pkg::ST_WAIT) ||
                    (st_nxt == scs_pkg::ST_PER);
  wire slv_nxt_w  = (st_nxt == scs_pkg::ST_PER) &&
                    (!pins_r.slow_peripheral_addr_valid_n || e_ph == `SCS_E_PH_SLOW);
  wire [1:0] lane_w = {req_in.lane_en[`SCS_LANE_UP] && mode_r, req_in.lane_en[0]};
  wire [1:0] lane_c = {cur_r.lane_en[`SCS_LANE_UP], cur_r.lane_en[0]};

  always_comb begin
    pins_nxt = pins_r;
    if (start_w) begin
      // codes pass through; cpu space forced on acknowledge
      pins_nxt.space_code = req_in.iack ? `SCS_FC_CPU : req_in.space_code;
      pins_nxt.addr       = req_in.addr;
      if (req_in.iack) pins_nxt.addr[19:16] = `SCS_IACK_ADDR_HI;
    end
    pins_nxt.addr_valid_strobe_n = !strb_nxt_w;
    pins_nxt.rd_wr_n             = !(strb_nxt_w && !cur_r.rd);
    pins_nxt.byte_lane_strobes_n = strb_nxt_w ? ~lane_c : 2'b11;
    pins_nxt.slow_peripheral_addr_valid_n = !slv_nxt_w;
  end

  // space code only reloads from idle, so it holds through the strobe
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pins_r <= '{addr: '0, space_code: '0, addr_valid_strobe_n: 1'b1, rd_wr_n: 1'b1,
                  byte_lane_strobes_n: 2'b11, slow_peripheral_addr_valid_n: 1'b1};
    end else begin
      pins_r <= pins_nxt;
    end
  end

  // request capture; upper lane dropped in 8-bit mode
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cur_r   <= '0;
      wdata_r <= '0;
    end else if (start_w) begin
      cur_r         <= req_in;
      cur_r.lane_en <= lane_w;
      wdata_r       <= req_in.wdata;
    end
  end

  // write data drive from strobe until end of cycle
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) wr_on_r <= 1'b0;
    else wr_on_r <= strb_nxt_w && !cur_r.rd;
  end

  ////////////////////////////////////////////////////////////////////////////
  // result: data latched as the cycle closes, one-cycle valid pulse
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rsp_r       <= '0;
      rsp_valid_r <= 1'b0;
    end else begin
      rsp_valid_r <= done_w;
      if (done_w) begin
        rsp_r.rdata   <= data_in;
        rsp_r.fault   <= fault_end_w;
        rsp_r.autovec <= cur_r.iack && (st_r == scs_pkg::ST_PER);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset instruction: line held low for a fixed count, core state kept
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rst_cnt_r <= `SCS_RST_CNT_ZERO;
      rst_drv_r <= 1'b0;
    end else begin
      if (reset_instr_in && !rst_drv_r) rst_cnt_r <= `SCS_RST_INSTR_CYC;
      else if (rst_drv_r) rst_cnt_r <= rst_cnt_r - `SCS_RST_CNT_STEP;
      rst_drv_r <= (reset_instr_in && !rst_drv_r) ||
                   (rst_drv_r && rst_cnt_r != `SCS_RST_CNT_STEP);
    end
  end

  // stop indication, system init, bus handover
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      halt_drv_r <= 1'b0;
      sys_init_r <= 1'b0;
      grant_r    <= 1'b0;
    end else begin
      halt_drv_r <= core_stopped_in;
      sys_init_r <= ext_rst_w && ext_halt_w;
      grant_r    <= relinquish_req_in && (idle_w ? !start_w : grant_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // width strap: default 16-bit in reset, caught on the release edge
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      in_rst_r <= 1'b1;
      mode_r   <= `SCS_MODE_16;
    end else begin
      in_rst_r <= 1'b0;
      if (in_rst_r) mode_r <= width_sel_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins: reset and halt are open drain, grant and enable always driven
  assign rst_line_n_out           = 1'b0;
  assign rst_line_oe_out          = rst_drv_r;
  assign halt_line_n_out          = 1'b0;
  assign halt_line_oe_out         = halt_drv_r;
  assign pins_out                 = pins_r;
  assign ctrl_oe_out              = !grant_r;
  assign addr_oe_out              = !grant_r && !halted_w;
  assign data_oe_out              = addr_oe_out && wr_on_r;
  assign data_out                 = wdata_r;
  assign bus_handover_grant_n_out = !grant_r;
  assign rsp_valid_out            = rsp_valid_r;
  assign rsp_out                  = rsp_r;
  assign sys_init_out             = sys_init_r;
  assign bus_8bit_out             = !mode_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  space_code_hold_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (!pins_r.addr_valid_strobe_n && $past(!pins_r.addr_valid_strobe_n))
    |-> $stable(pins_r.space_code))
    else $error("space code moved under address strobe");

  iack_marker_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (!pins_r.addr_valid_strobe_n && cur_r.iack)
    |-> (pins_r.space_code == `SCS_FC_CPU && pins_r.addr[19:16] == `SCS_IACK_ADDR_HI))
    else $error("acknowledge cycle not marked high");

  slow_valid_sel_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    $fell(pins_r.slow_peripheral_addr_valid_n)
    |-> (st_r == scs_pkg::ST_PER && $past(e_ph) == `SCS_E_PH_SLOW))
    else $error("valid address strobe without peripheral select");

  halt_float_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (ext_halt_w && idle_w) |-> (!addr_oe_out && !data_oe_out && ctrl_oe_out == !grant_r))
    else $error("buses driven while halted");

  relinquish_float_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    grant_r |-> (!ctrl_oe_out && !addr_oe_out && !bus_handover_grant_n_out))
    else $error("outputs driven after bus handover");

  reset_instr_len_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    $rose(rst_drv_r) |-> rst_drv_r [*8] ##1 (rst_cnt_r == `SCS_RST_INSTR_CYC - 8'h08))
    else $error("reset line released early");

  fault_rerun_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (st_r == scs_pkg::ST_WAIT && fault_w && ext_halt_w)
    |=> (st_r == scs_pkg::ST_RERUN && !rsp_valid_out))
    else $error("fault with halt did not rerun");

  fault_exc_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (st_r == scs_pkg::ST_WAIT && fault_w && !ext_halt_w) |=> (rsp_valid_out && rsp_out.fault))
    else $error("fault not reported");

  halt_drive_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    core_stopped_in |=> (halt_line_oe_out && !req_ready_out))
    else $error("halt line not driven on stop");

  mode_hold_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (!in_rst_r && !$past(in_rst_r)) |-> $stable(mode_r))
    else $error("bus width changed after reset");

  sys_init_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (ext_rst_w && ext_halt_w) |=> sys_init_out)
    else $error("system init missed");

endmodule : scs_sys_ctrl

// ---- core/scs_defs.svh ----
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH

// enable clock ring: ten phases, phases 6..9 high
`define SCS_E_PH_W        4
`define SCS_E_PH_FIRST    4'h0
`define SCS_E_PH_LAST     4'h9
`define SCS_E_PH_HIGH     4'h6
`define SCS_E_PH_STEP     4'h1
`define SCS_E_PH_SLOW     4'h3

// space codes
`define SCS_FC_CPU        3'h7

// interrupt acknowledge marker on address bits 19..16
`define SCS_IACK_ADDR_HI  4'hf

// bus width strap: 1 = 16-bit, 0 = 8-bit
`define SCS_MODE_16       1'b1

// reset-instruction drive length in clocks
`define SCS_RST_CNT_W     8
`define SCS_RST_INSTR_CYC 8'h7c
`define SCS_RST_CNT_ZERO  8'h00
`define SCS_RST_CNT_STEP  8'h01

// byte lane strobes: upper lane index
`define SCS_LANE_UP       1

`endif

// ---- core/scs_pkg.sv ----
package scs_pkg;

  // bus cycle request from the core
  typedef struct packed {
    logic [2:0]  space_code;
    logic        rd;
    logic        iack;
    logic [1:0]  lane_en;
    logic [23:0] addr;
    logic [15:0] wdata;
  } scs_req_s;

  // bus cycle result back to the core
  typedef struct packed {
    logic [15:0] rdata;
    logic        fault;
    logic        autovec;
  } scs_rsp_s;

  // registered bus pin values
  typedef struct packed {
    logic [23:0] addr;
    logic [2:0]  space_code;
    logic        addr_valid_strobe_n;
    logic        rd_wr_n;
    logic [1:0]  byte_lane_strobes_n;
    logic        slow_peripheral_addr_valid_n;
  } scs_pins_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_STRB,
    ST_WAIT,
    ST_PER,
    ST_END,
    ST_RERUN
  } scs_state_e;

endpackage : scs_pkg

// ---- core/scs_eclk_gen.sv ----
`timescale 1ns/1ns
`include "scs_defs.svh"

module scs_eclk_gen (
  input  wire logic                     core_clk_in,
  input  wire logic                     rst_n_in,
  output logic                          e_clk_out,
  output logic [`SCS_E_PH_W-1:0]        e_phase_out
);

  logic [`SCS_E_PH_W-1:0] ph_r;
  logic [`SCS_E_PH_W-1:0] ph_nxt;
  logic                   e_r;

  // wrap also catches stray codes above the last phase
  assign ph_nxt = (ph_r >= `SCS_E_PH_LAST) ? `SCS_E_PH_FIRST : ph_r + `SCS_E_PH_STEP;

  ////////////////////////////////////////////////////////////////////////////
  // free-running ring; reset only fixes a phase, nothing else stops it
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ph_r <= `SCS_E_PH_FIRST;
      e_r  <= 1'b0;
    end else begin
      ph_r <= ph_nxt;
      e_r  <= (ph_nxt >= `SCS_E_PH_HIGH);
    end
  end

  assign e_clk_out   = e_r;
  assign e_phase_out = ph_r;

  ////////////////////////////////////////////////////////////////////////////
  e_period_shape_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    $rose(e_r) |-> e_r [*4] ##1 !e_r [*6] ##1 e_r)
    else $error("enable clock not four high six low");

endmodule : scs_eclk_gen

// ---- tb/scs_far_side.sv ----
`timescale 1ns/1ns

// far-side model: memory, slow peripheral and fault logic behind the pins
module scs_far_side (
  input  wire logic               core_clk_in,
  input  wire scs_pkg::scs_pins_s pins_in,
  input  wire logic [1:0]         mode_in,
  input  wire logic [3:0]         delay_in,
  output logic                    transfer_ack_n_out,
  output logic                    bus_fault_n_out,
  output logic                    slow_sel_n_out,
  output logic [15:0]             data_out
);
  logic [3:0] wait_r = 4'h0;
  logic       hit;

  initial begin
    transfer_ack_n_out = 1'b1;
    bus_fault_n_out    = 1'b1;
    slow_sel_n_out     = 1'b1;
    data_out           = 16'h0000;
  end

  // answer only after the strobe has been low for delay_in clocks
  assign hit = !pins_in.addr_valid_strobe_n && (wait_r >= delay_in);

  ////////////////////////////////////////////////////////////////////////////
  // responses are pulled-up lines, released one clock after the strobe goes high
  always @(posedge core_clk_in) begin
    wait_r <= pins_in.addr_valid_strobe_n ? 4'h0 : wait_r + 4'h1;
    transfer_ack_n_out <= !(hit && mode_in == 2'd0);
    bus_fault_n_out <= !(hit && mode_in == 2'd1);
    slow_sel_n_out <= !(hit && mode_in == 2'd2);
    // undriven data bus churns so a late latch shows up as a mismatch
    if (!pins_in.addr_valid_strobe_n && pins_in.rd_wr_n) begin
      data_out <= {pins_in.addr[7:0], ~pins_in.addr[7:0]};
    end else begin
      data_out <= ~data_out;
    end
  end
endmodule : scs_far_side

// ---- tb/scs_sys_ctrl_tb_top.sv ----
`timescale 1ns/1ns

module scs_sys_ctrl_tb_top;
  logic               core_clk_in, rst_n_in, req_valid, reset_instr, core_stopped;
  logic               relinquish, width_sel, ext_rst_low, ext_halt_low;
  logic [1:0]         fs_mode;
  logic [3:0]         fs_delay;
  scs_pkg::scs_req_s  req;
  scs_pkg::scs_rsp_s  rsp, got_rsp;
  scs_pkg::scs_pins_s pins;
  logic               req_ready, rsp_valid, sys_init, bus_8bit, ack_n, fault_n, sel_n;
  logic               rst_oe, halt_oe, addr_oe, ctrl_oe, data_oe, grant_n, e_clk;
  logic [15:0]        data_rd, data_wr, seen_wd;
  logic [2:0]         seen_fc;
  logic [3:0]         seen_hi;
  logic [1:0]         seen_lanes;
  logic               seen_slow_valid, seen_rw;
  int                 miscompares = 0;
  int                 checks_done = 0;
  int                 cycles = 0;

  // steady free-running clock, never gated
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end

  scs_sys_ctrl DUT (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid),
    .req_in(req), .req_ready_out(req_ready), .rsp_valid_out(rsp_valid), .rsp_out(rsp),
    .reset_instr_in(reset_instr), .core_stopped_in(core_stopped),
    .relinquish_req_in(relinquish), .sys_init_out(sys_init), .bus_8bit_out(bus_8bit),
    .bus_fault_n_in(fault_n), .transfer_ack_n_in(ack_n),
    .slow_peripheral_select_n_in(sel_n), .width_sel_in(width_sel),
    .rst_line_n_in(!(rst_oe || ext_rst_low)), .rst_line_n_out(), .rst_line_oe_out(rst_oe),
    .halt_line_n_in(!(halt_oe || ext_halt_low)), .halt_line_n_out(),
    .halt_line_oe_out(halt_oe), .pins_out(pins), .addr_oe_out(addr_oe),
    .ctrl_oe_out(ctrl_oe), .data_in(data_rd), .data_out(data_wr), .data_oe_out(data_oe),
    .bus_handover_grant_n_out(grant_n), .periph_en_clk_out(e_clk)
  );

  scs_far_side FAR (
    .core_clk_in(core_clk_in), .pins_in(pins), .mode_in(fs_mode), .delay_in(fs_delay),
    .transfer_ack_n_out(ack_n), .bus_fault_n_out(fault_n), .slow_sel_n_out(sel_n),
    .data_out(data_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic tick();
    @(posedge core_clk_in);
    #1;
  endtask : tick

  task automatic check_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bit

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  // hang guard, generous against the few hundred clocks the run needs
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // strap held through reset and two clocks after, then moved to prove it is latched
  task automatic do_reset(input logic strap);
    width_sel = strap;
    rst_n_in = 1'b0;
    repeat (8) tick();
    rst_n_in = 1'b1;
    repeat (2) tick();
    width_sel = !strap;
    repeat (3) tick();
    check_bit(bus_8bit, !strap);
  endtask : do_reset

  // one core cycle: request held until taken, pins watched until the result
  task automatic bus_cycle(input logic [2:0] fc, input logic rd, input logic iack,
                           input logic [23:0] a);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      tick();
      n++;
    end
    req = '{space_code: fc, rd: rd, iack: iack, lane_en: 2'b11, addr: a, wdata: 16'h5aa5};
    req_valid = 1'b1;
    tick();
    req_valid = 1'b0;
    seen_slow_valid = 1'b0;
    seen_fc = 3'h0;
    seen_wd = 16'h0000;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 100) begin
      if (pins.addr_valid_strobe_n === 1'b0) begin
        seen_fc = pins.space_code;
        seen_hi = pins.addr[19:16];
        seen_lanes = pins.byte_lane_strobes_n;
        seen_rw = pins.rd_wr_n;
      end
      if (data_oe === 1'b1) seen_wd = data_wr;
      if (pins.slow_peripheral_addr_valid_n === 1'b0) seen_slow_valid = 1'b1;
      tick();
      n++;
    end
    got_rsp = rsp;
    check_bit(rsp_valid, 1'b1);
  endtask : bus_cycle

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_eclk();
    logic e [24];
    int   i, r, hi;
    for (i = 0; i < 24; i++) begin
      e[i] = e_clk;
      tick();
    end
    r = 0;
    for (i = 1; i < 12; i++) if (r == 0 && !e[i-1] && e[i]) r = i;
    hi = 0;
    for (i = r; i < r + 10; i++) hi += e[i];
    check_word(hi[15:0], 16'h0004);
    check_bit(e[r+4], 1'b0);
    check_bit(e[r+10], 1'b1);
  endtask : t_eclk

  // every defined space code, one write among them, growing acknowledge delay
  task automatic t_codes();
    logic [2:0]  codes [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
    logic [23:0] a;
    int          i;
    for (i = 0; i < 5; i++) begin
      fs_delay = i[3:0];
      a = 24'h00_00a0 + i[23:0];
      bus_cycle(codes[i], i != 1, 1'b0, a);
      check_word({13'h0000, seen_fc}, {13'h0000, codes[i]});
      check_bit(got_rsp.fault, 1'b0);
      check_bit(seen_slow_valid, 1'b0);
      check_word({14'h0000, seen_lanes}, 16'h0002);
      check_bit(seen_rw, i != 1);
      check_word(seen_wd, (i == 1) ? 16'h5aa5 : 16'h0000);
      if (i != 1) check_word(got_rsp.rdata, {a[7:0], ~a[7:0]});
    end
    fs_delay = 4'h0;
  endtask : t_codes

  task automatic t_fault_and_slow();
    fs_mode = 2'd1;
    bus_cycle(3'h1, 1'b1, 1'b0, 24'h00_0200);
    check_bit(got_rsp.fault, 1'b1);
    fs_mode = 2'd2;
    bus_cycle(3'h7, 1'b1, 1'b1, 24'h00_0000);
    check_bit(got_rsp.autovec, 1'b1);
    check_bit(seen_slow_valid, 1'b1);
    check_word({12'h000, seen_hi}, 16'h000f);
    bus_cycle(3'h5, 1'b1, 1'b0, 24'h00_0300);
    check_bit(got_rsp.autovec, 1'b0);
    check_bit(seen_slow_valid, 1'b1);
    fs_mode = 2'd0;
  endtask : t_fault_and_slow

  task automatic t_reset_instr();
    logic m;
    int   n, i;
    m = bus_8bit;
    reset_instr = 1'b1;
    tick();
    reset_instr = 1'b0;
    n = 0;
    for (i = 0; i < 200; i++) begin
      n += (rst_oe === 1'b1);
      tick();
    end
    check_word(n[15:0], 16'h007c);
    check_bit(bus_8bit, m);
  endtask : t_reset_instr

  // outside halt, core stop, bus handover and system init, each released again
  task automatic t_lines();
    int i, hi;
    ext_halt_low = 1'b1;
    repeat (3) tick();
    check_bit(req_ready, 1'b0);
    check_bit(pins.addr_valid_strobe_n, 1'b1);
    check_word({13'h0000, addr_oe, data_oe, ctrl_oe}, 16'h0001);
    ext_halt_low = 1'b0;
    repeat (2) tick();
    check_bit(req_ready, 1'b1);
    core_stopped = 1'b1;
    tick();
    check_bit(halt_oe, 1'b1);
    core_stopped = 1'b0;
    repeat (2) tick();
    check_bit(halt_oe, 1'b0);
    relinquish = 1'b1;
    repeat (2) tick();
    check_word({12'h000, grant_n, addr_oe, data_oe, ctrl_oe}, 16'h0000);
    hi = 0;
    for (i = 0; i < 10; i++) begin
      hi += (e_clk === 1'b1);
      tick();
    end
    check_word(hi[15:0], 16'h0004);
    relinquish = 1'b0;
    repeat (2) tick();
    check_bit(grant_n, 1'b1);
    ext_rst_low = 1'b1;
    ext_halt_low = 1'b1;
    repeat (2) tick();
    check_bit(sys_init, 1'b1);
    ext_rst_low = 1'b0;
    ext_halt_low = 1'b0;
    repeat (2) tick();
    check_bit(sys_init, 1'b0);
  endtask : t_lines

  // fault under outside halt: no result, address floats, cycle runs again on release
  task automatic t_rerun();
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      tick();
      n++;
    end
    fs_mode = 2'd1;
    req = '{space_code: 3'h1, rd: 1'b1, iack: 1'b0, lane_en: 2'b11, addr: 24'h00_0410,
            wdata: 16'h0000};
    req_valid = 1'b1;
    tick();
    req_valid = 1'b0;
    ext_halt_low = 1'b1;
    repeat (5) tick();
    check_bit(addr_oe, 1'b0);
    check_bit(rsp_valid, 1'b0);
    fs_mode = 2'd0;
    ext_halt_low = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    check_bit(rsp_valid, 1'b1);
    check_bit(rsp.fault, 1'b0);
    check_word(rsp.rdata, 16'h10ef);
  endtask : t_rerun

  // 16-bit strap: both lanes strobed on a write, data driven with the strobe
  task automatic t_wide();
    bus_cycle(3'h5, 1'b0, 1'b0, 24'h00_0050);
    check_word({14'h0000, seen_lanes}, 16'h0000);
    check_bit(seen_rw, 1'b0);
    check_word(seen_wd, 16'h5aa5);
  endtask : t_wide

  ////////////////////////////////////////////////////////////////////////////
  // main sequence: 8-bit strap first, 16-bit on the closing reset
  initial begin
    rst_n_in = 1'b0;
    req_valid = 1'b0;
    req = '0;
    reset_instr = 1'b0;
    core_stopped = 1'b0;
    relinquish = 1'b0;
    width_sel = 1'b0;
    ext_rst_low = 1'b0;
    ext_halt_low = 1'b0;
    fs_mode = 2'd0;
    fs_delay = 4'h0;
    do_reset(1'b0);
    t_eclk();
    t_codes();
    t_fault_and_slow();
    t_rerun();
    t_reset_instr();
    t_lines();
    do_reset(1'b1);
    t_wide();
    report_and_stop();
  end
endmodule : scs_sys_ctrl_tb_top
